// *** shared/adc_readout_pkg.sv ***
/*
  Constants and types for the conversion control and readout block.
  Assumes a 100 MHz system clock and a master conversion clock derived from it.
*/
package adc_readout_pkg;
  localparam int SYS_PERIOD_NS = 10;
  localparam int TCLK_NS = 488;
  localparam logic [5:0] TCLK_DIV_M1 = 6'(TCLK_NS / SYS_PERIOD_NS - 1);
  localparam int CHANS = 8;
  localparam int WORD_W = 24;
  localparam int RAW_W = 26;
  localparam int FRAME_W = 216;
  localparam int FIFO_DEPTH = 8;
  localparam logic [7:0] LAST_BIT = 8'hD7;
  localparam logic [3:0] LAST_CHAN = 4'h7;
  localparam logic [3:0] STATUS_HEAD = 4'hC;
  localparam logic [23:0] POS_FULL = 24'h7FFFFF;
  localparam logic [23:0] NEG_FULL = 24'h800000;
  localparam logic [15:0] STOP_SETUP_TCLK = 16'h0010;
  localparam logic [15:0] STOP_HOLD_TCLK = 16'h0010;
  localparam logic [2:0] CONVERSION_READY_N_PULSE_TCLK = 3'h4;
  localparam int SETTLE_FACTOR = 4;
  localparam int SINGLE_SHOT_BIT = 3;
  localparam int CHAIN_EN_BIT = 6;
  localparam logic CONT_READ_RESET = 1'b1;
  localparam logic [2:0] CMD_EARLY_EDGE = 3'h6;
  localparam logic [2:0] CMD_LAST_EDGE = 3'h7;
  localparam logic [7:0] CMD_START = 8'h08;
  localparam logic [7:0] CMD_STOP = 8'h0A;
  localparam logic [7:0] CMD_CONT_READ = 8'h10;
  localparam logic [7:0] CMD_STOP_CONT_READ = 8'h11;
  localparam logic [7:0] CMD_READ_ONCE = 8'h12;
  typedef enum logic [1:0] {C_IDLE, C_RUN, C_LOAD} conv_state_t;
endpackage

// *** shared/stream_if.sv ***
/*
  Valid/ready word stream between the block's own modules.
  Assumes both ends run on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(parameter int W = 26);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// *** src/adc_conversion_readout.sv ***
/*
  Conversion control and serial frame readout for an eight-channel converter.
  Assumes raw channel samples arrive in channel order on the sample stream,
  and that the serial link pins come from outside the clk_sys domain.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_readout #(
  parameter int CONV_TCLK = 512
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Control and serial pins
  input wire logic startPin,
  input wire logic spiCsN,
  input wire logic spiSclk,
  input wire logic spiDin,
  output var logic spiDout,
  output var logic spiDoutOe,
  output var logic conversionReadyN,
  // Configuration and flags
  input wire logic [7:0] configRegOne,
  input wire logic [7:0] configRegFour,
  input wire logic [7:0] chanPowerDown,
  input wire logic [7:0] leadOffFlagsPos,
  input wire logic [7:0] leadOffFlagsNeg,
  input wire logic [7:0] gpioData,
  // Raw sample stream
  input wire logic [adc_readout_pkg::RAW_W-1:0] sampleData,
  input wire logic sampleValid,
  output var logic sampleReady,
  // Status
  output var logic convActive,
  output var logic contReadMode
);
  localparam int FW = adc_readout_pkg::FRAME_W;
  localparam int WW = adc_readout_pkg::WORD_W;
  localparam int RW = adc_readout_pkg::RAW_W;
  // Overwrite pulse length in system clocks (four whole master periods)
  localparam int PULSE_CYC = int'(adc_readout_pkg::CONVERSION_READY_N_PULSE_TCLK) *
                             (int'(adc_readout_pkg::TCLK_DIV_M1) + 1);

  typedef struct packed {
    adc_readout_pkg::conv_state_t cst;
    logic [15:0] convCnt;
    logic first;
    logic ssMode;
    logic stopAt;
    logic stopNext;
    logic busy;
    logic [5:0] tdiv;
    logic drdyN;
    logic [7:0] pulseCnt;
    logic [3:0] loadCnt;
    logic [FW-1:0] frame;
    logic [FW-1:0] sh;
    logic [7:0] bitIdx;
    logic dout;
    logic doutOe;
    logic [7:0] cmdSh;
    logic [2:0] cmdBits;
    logic contRead;
    logic sclkPrev;
    logic startPrev;
  } ctl_t;
  ctl_t stReg;
  ctl_t stNext;

  logic startS;
  logic csS;
  logic sclkS;
  logic dinS;
  logic sclkRise;
  logic sclkFall;
  logic tick;
  logic cmdStart;
  logic cmdStop;
  logic startEv;
  logic stopEv;
  logic done;
  logic chainOn;
  logic [15:0] target;
  logic [WW-1:0] word;
  logic [RW-1:0] raw;

  stream_if #(.W(RW)) fifoIn ();
  stream_if #(.W(RW)) fifoOut ();

  ////////////////////////////////////////////////////////////////////////////
  pin_sync #(.W(4), .INIT(4'h4)) u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .d({startPin, spiCsN, spiSclk, spiDin}),
    .q({startS, csS, sclkS, dinS})
  );

  assign fifoIn.valid = sampleValid;
  assign fifoIn.data = sampleData;

  // Back-pressure: the FIFO only drains during frame assembly
  sample_fifo #(.W(RW), .DEPTH(adc_readout_pkg::FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .srst(srst),
    .inS(fifoIn.snk),
    .outS(fifoOut.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    stNext = stReg;
    cmdStart = 1'b0;
    cmdStop = 1'b0;
    done = 1'b0;
    fifoOut.ready = 1'b0;
    sclkRise = sclkS && !stReg.sclkPrev;
    sclkFall = !sclkS && stReg.sclkPrev;
    tick = (stReg.tdiv == '0);
    chainOn = stReg.contRead && configRegOne[adc_readout_pkg::CHAIN_EN_BIT];
    stNext.sclkPrev = sclkS;
    stNext.startPrev = startS;
    stNext.tdiv = tick ? adc_readout_pkg::TCLK_DIV_M1 : stReg.tdiv - 6'h01;

    // Clip to 24 bits; in-range values pass unchanged
    raw = fifoOut.data;
    if (&raw[RW-1:WW-1] || ~|raw[RW-1:WW-1]) begin
      word = raw[WW-1:0];
    end else if (raw[RW-1]) begin
      word = adc_readout_pkg::NEG_FULL;
    end else begin
      word = adc_readout_pkg::POS_FULL;
    end
    if (chanPowerDown[stReg.loadCnt[2:0]]) begin
      word = '0;
    end

    // Serial side; a high select resets the bit index and command counter, the shifter keeps its contents
    if (csS) begin
      stNext.doutOe = 1'b0;
      stNext.cmdBits = '0;
      stNext.bitIdx = '0;
    end else begin
      stNext.doutOe = 1'b1;
      if (sclkRise) begin
        stNext.dout = stReg.sh[FW-1];
        stNext.bitIdx = (stReg.bitIdx == adc_readout_pkg::LAST_BIT) ? 8'h00 :
                        stReg.bitIdx + 8'h01;
        // Chained continuous read rotates so the frame repeats
        stNext.sh = {stReg.sh[FW-2:0], chainOn & stReg.sh[FW-1]};
      end
      if (sclkFall) begin
        stNext.cmdSh = {stReg.cmdSh[6:0], dinS};
        stNext.cmdBits = stReg.cmdBits + 3'h1;
        if (stReg.cmdBits == adc_readout_pkg::CMD_EARLY_EDGE) begin
          case ({stReg.cmdSh[5:0], dinS})
            adc_readout_pkg::CMD_START[7:1]: begin
              cmdStart = 1'b1;
            end
            adc_readout_pkg::CMD_STOP[7:1]: begin
              cmdStop = 1'b1;
            end
            adc_readout_pkg::CMD_READ_ONCE[7:1]: begin
              stNext.sh = stReg.frame;
              stNext.bitIdx = '0;
            end
            default: begin
            end
          endcase
        end
        // Read-mode commands differ only in their last bit
        if (stReg.cmdBits == adc_readout_pkg::CMD_LAST_EDGE) begin
          case ({stReg.cmdSh[6:0], dinS})
            adc_readout_pkg::CMD_CONT_READ: begin
              stNext.contRead = 1'b1;
            end
            adc_readout_pkg::CMD_STOP_CONT_READ: begin
              stNext.contRead = 1'b0;
            end
            default: begin
            end
          endcase
        end
      end
    end
    if (sclkFall) begin
      stNext.drdyN = 1'b1;
    end

    // Short high pulse on the ready output for an overwritten result;
    // counted in system clocks since the result lands mid master period
    if (stReg.pulseCnt != '0) begin
      stNext.pulseCnt = stReg.pulseCnt - 8'h01;
      if (stReg.pulseCnt == 8'h01) begin
        stNext.drdyN = 1'b0;
      end
    end

    // Conversion sequencing
    startEv = cmdStart || (startS && !stReg.startPrev);
    stopEv = cmdStop || (!startS && stReg.startPrev);
    target = stReg.first ? 16'(CONV_TCLK * adc_readout_pkg::SETTLE_FACTOR) :
             16'(CONV_TCLK);
    if (startEv) begin
      // Restart also resynchronises and resets the filter
      stNext.cst = adc_readout_pkg::C_RUN;
      stNext.convCnt = '0;
      stNext.first = 1'b1;
      stNext.stopAt = 1'b0;
      stNext.stopNext = 1'b0;
      stNext.ssMode = configRegFour[adc_readout_pkg::SINGLE_SHOT_BIT];
      stNext.drdyN = 1'b1;
      stNext.pulseCnt = '0;
    end else begin
      if (stopEv && stReg.cst != adc_readout_pkg::C_IDLE) begin
        // Too close to the next result: the conversion after it also completes
        if (target - stReg.convCnt < adc_readout_pkg::STOP_SETUP_TCLK) begin
          stNext.stopNext = 1'b1;
        end else begin
          stNext.stopAt = 1'b1;
        end
      end
      case (stReg.cst)
        adc_readout_pkg::C_RUN: begin
          if (tick) begin
            stNext.convCnt = stReg.convCnt + 16'h0001;
            if (stNext.convCnt == target) begin
              stNext.cst = adc_readout_pkg::C_LOAD;
              stNext.loadCnt = '0;
            end
          end
        end
        adc_readout_pkg::C_LOAD: begin
          fifoOut.ready = 1'b1;
          if (fifoOut.valid) begin
            stNext.frame[FW-WW-1:0] = {stReg.frame[FW-2*WW-1:0], word};
            stNext.loadCnt = stReg.loadCnt + 4'h1;
            done = (stReg.loadCnt == adc_readout_pkg::LAST_CHAN);
          end
        end
        default: begin
        end
      endcase
    end

    if (done) begin
      stNext.frame[FW-1:FW-WW] = {adc_readout_pkg::STATUS_HEAD, leadOffFlagsPos,
                                  leadOffFlagsNeg, gpioData[7:4]};
      if (stReg.contRead) begin
        stNext.sh = stNext.frame;
        stNext.bitIdx = '0;
      end
      if (!stReg.drdyN && !sclkFall) begin
        stNext.drdyN = 1'b1;
        stNext.pulseCnt = 8'(PULSE_CYC);
      end else begin
        stNext.drdyN = 1'b0;
      end
      stNext.convCnt = '0;
      stNext.first = 1'b0;
      if (stReg.ssMode || stReg.stopAt) begin
        stNext.cst = adc_readout_pkg::C_IDLE;
      end else begin
        stNext.cst = adc_readout_pkg::C_RUN;
        stNext.stopAt = stNext.stopNext;
        stNext.stopNext = 1'b0;
      end
    end
    stNext.busy = (stNext.cst != adc_readout_pkg::C_IDLE);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stReg <= '0;
      stReg.drdyN <= 1'b1;
      stReg.contRead <= adc_readout_pkg::CONT_READ_RESET;
    end else begin
      stReg <= stNext;
    end
  end

  assign spiDout = stReg.dout;
  assign spiDoutOe = stReg.doutOe;
  assign conversionReadyN = stReg.drdyN;
  assign sampleReady = fifoIn.ready;
  assign convActive = stReg.busy;
  assign contReadMode = stReg.contRead;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  a_dout_release: assert property (csS |=> !stReg.doutOe)
    else $error("output enable stayed on with select high");
  a_msb_first: assert property (sclkRise && !csS |=> stReg.dout == $past(stReg.sh[FW-1]))
    else $error("serial output is not the shifter MSB");
  a_ready_sclk: assert property (sclkFall && !done |=> stReg.drdyN)
    else $error("ready output not raised by serial falling edge");
  a_status_head: assert property (done |=> stReg.frame[FW-1:FW-4] == 4'hC)
    else $error("status word head is wrong");
  a_pd_zero: assert property (stReg.cst == adc_readout_pkg::C_LOAD && fifoOut.valid &&
      chanPowerDown[stReg.loadCnt[2:0]] && !startEv |=> stReg.frame[WW-1:0] == '0)
    else $error("powered-down channel word not zero");
  a_chain_wrap: assert property (sclkRise && !csS && chainOn |=>
      stReg.sh[0] == $past(stReg.sh[FW-1]))
    else $error("chained read does not rotate the frame");
  a_start_high: assert property (startEv |=> stReg.drdyN && stReg.busy ##1 stReg.busy)
    else $error("start did not raise ready and run");
  a_single_halt: assert property (done && stReg.ssMode && !startEv |=> !stReg.busy)
    else $error("single shot kept converting");
  a_ready_pulse: assert property (done && !stReg.drdyN && !sclkFall |=>
      stReg.drdyN && stReg.pulseCnt == 8'(PULSE_CYC))
    else $error("overwrite pulse not started");
  a_sat_pos: assert property (stReg.cst == adc_readout_pkg::C_LOAD && fifoOut.valid && !startEv &&
      !raw[RW-1] && |raw[RW-2:WW-1] && !chanPowerDown[stReg.loadCnt[2:0]] |=>
      stReg.frame[WW-1:0] == 24'h7FFFFF)
    else $error("positive overrange not clipped");

  c_cont_frame: cover property (done && stReg.contRead);
  c_overwrite: cover property (done && !stReg.drdyN);
  c_single: cover property (done && stReg.ssMode);
  c_wrap: cover property (sclkRise && chainOn && stReg.bitIdx == adc_readout_pkg::LAST_BIT);
endmodule // adc_conversion_readout
`default_nettype wire

// *** src/pin_sync.sv ***
/*
  Two-flop synchroniser for a group of asynchronous pins.
  Assumes the pins are quasi-static against clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Pins in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;
  sync_t stReg;
  sync_t stNext;

  always_comb begin
    stNext.s1 = d;
    stNext.s2 = stReg.s1;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stReg <= {INIT, INIT};
    end else begin
      stReg <= stNext;
    end
  end

  assign q = stReg.s2;
endmodule // pin_sync
`default_nettype wire

// *** src/sample_fifo.sv ***
/*
  Small FIFO for raw channel samples, valid/ready on both sides.
  Assumes DEPTH is a power of two; ready on the write side is a flop.
*/
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int W = 26,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Streams
  stream_if.snk inS,
  stream_if.src outS
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic room;
  } fifo_t;
  fifo_t stReg;
  fifo_t stNext;
  logic push;
  logic pop;

  always_comb begin
    stNext = stReg;
    push = inS.valid && stReg.room;
    pop = outS.ready && (stReg.cnt != '0);
    if (push) begin
      stNext.mem[stReg.wp] = inS.data;
      stNext.wp = stReg.wp + 1'b1;
    end
    if (pop) begin
      stNext.rp = stReg.rp + 1'b1;
    end
    stNext.cnt = stReg.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    // Registered room keeps the source stall free of combinational paths
    stNext.room = (stNext.cnt != (AW + 1)'(DEPTH));
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stReg <= '0;
      stReg.room <= 1'b1;
    end else begin
      stReg <= stNext;
    end
  end

  assign inS.ready = stReg.room;
  assign outS.valid = (stReg.cnt != '0);
  assign outS.data = stReg.mem[stReg.rp];
endmodule // sample_fifo
`default_nettype wire

// *** tb/adc_conversion_readout_tb.sv ***
/*
  Testbench for the conversion control and readout block.
  Assumes the host model drives the link and the bench feeds samples.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_readout_tb;
  localparam int CONV = 90;
  localparam int PER = CONV * 48;
  logic clk_sys, srst, startPin, spiCsN, spiSclk, spiDin, spiDout, spiDoutOe;
  logic conversionReadyN, sampleValid, sampleReady, convActive, contReadMode;
  logic [7:0] configRegOne, configRegFour, chanPowerDown;
  logic [7:0] leadOffFlagsPos, leadOffFlagsNeg, gpioData;
  logic [adc_readout_pkg::RAW_W-1:0] sampleData;
  logic [adc_readout_pkg::RAW_W-1:0] q[$];
  logic [215:0] expFrame;
  logic [23:0] smp;
  logic [255:0] got;
  logic rdy;
  int error_cnt = 0;
  int checked = 0;
  int falls = 0;
  int f, n;

  adc_conversion_readout #(.CONV_TCLK(CONV)) dut (.clk_sys, .srst, .startPin, .spiCsN,
    .spiSclk, .spiDin, .spiDout, .spiDoutOe, .conversionReadyN, .configRegOne,
    .configRegFour, .chanPowerDown, .leadOffFlagsPos, .leadOffFlagsNeg, .gpioData,
    .sampleData, .sampleValid, .sampleReady, .convActive, .contReadMode);
  spi_host_model host (.spiCsN, .spiSclk, .spiDin, .spiDout, .spiDoutOe, .conversionReadyN);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Reference model
  function automatic logic [23:0] clip(logic [25:0] s);
    if ($signed(s) > $signed(26'h07FFFFF)) return 24'h7FFFFF;
    if ($signed(s) < $signed(26'h3800000)) return 24'h800000;
    return s[23:0];
  endfunction

  // Each result takes the oldest eight samples, channel order kept
  always @(negedge conversionReadyN) if (!srst) begin
    falls++;
    expFrame = {4'hC, leadOffFlagsPos, leadOffFlagsNeg, gpioData[7:4]};
    for (int c = 0; c < 8; c++) begin
      // A powered-down channel still uses up its sample
      smp = clip(q.pop_front());
      expFrame = {expFrame[191:0], chanPowerDown[c] ? 24'h000000 : smp};
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [25:0] pick();
    logic [25:0] r;
    r = 26'($urandom);
    case ($urandom_range(4))
      0: return r;
      1: return {{2{r[23]}}, r[23:0]};
      2: return 26'h07FFFFF + 26'($urandom_range(2)) - 26'h0000001;
      3: return 26'h3800000 + 26'($urandom_range(2)) - 26'h0000001;
      default: return 26'($urandom_range(2)) - 26'h0000001;
    endcase
  endfunction

  task automatic feed();
    forever begin
      @(posedge clk_sys);
      if (!srst && sampleValid && sampleReady) q.push_back(sampleData);
      if (!sampleValid || sampleReady) begin
        sampleValid <= 1'b1;
        sampleData <= pick();
      end
    end
  endtask

  task automatic clks(int k);
    repeat (k) @(posedge clk_sys);
  endtask

  task automatic chk(logic [255:0] seen, logic [255:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic waitFall(input int lim, output int k);
    int f0;
    f0 = falls;
    k = 0;
    while (falls == f0 && k < lim) begin
      @(posedge clk_sys);
      k++;
    end
    chk(falls != f0, 1'b1);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Watchdog: the sequence needs about 90000 cycles
  initial begin
    clks(99000);
    error_cnt++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'h618A025B));
    {srst, startPin, sampleValid} = 3'h4;
    sampleData = '0;
    configRegOne = 8'h40;
    configRegFour = 8'h00;
    chanPowerDown = 8'($urandom);
    {leadOffFlagsPos, leadOffFlagsNeg, gpioData} = 24'($urandom);
    fork
      feed();
    join_none
    clks(6);
    srst <= 1'b0;
    clks(30);
    chk(contReadMode, 1'b1);
    chk(sampleReady, 1'b0); // Buffer refuses when full
    chk(q.size(), 8); // Buffer holds eight words
    // Continuous run from the pin, chained read
    startPin <= 1'b1;
    clks(8);
    chk(convActive, 1'b1);
    waitFall(5 * PER, n);
    chk(n > 3 * PER, 1'b1);
    host.shift(8'h00, 224, got, rdy);
    chk(got[223:8], expFrame);
    chk(got[7:0], expFrame[215:208]);
    chk(rdy, 1'b1);
    $display("test continuous read done");
    // Unread result is overwritten
    waitFall(2 * PER, n);
    chk(n < PER, 1'b1);
    for (n = 0; n < 2 * PER && conversionReadyN !== 1'b1; n++) clks(1);
    for (n = 0; n < 400 && conversionReadyN === 1'b1; n++) clks(1);
    chk(n >= 188 && n <= 196, 1'b1);
    $display("test overwrite done");
    // Early stop by pin lets one conversion finish
    f = falls;
    startPin <= 1'b0;
    clks(2 * PER);
    chk(falls - f, 1);
    chk(convActive, 1'b0);
    $display("test pin stop done");
    // Single shot from a pin rising edge, then on-demand read
    configRegFour <= 8'h08;
    clks(2);
    chk(conversionReadyN, 1'b0);
    startPin <= 1'b1;
    f = falls;
    clks(8);
    chk(conversionReadyN, 1'b1);
    waitFall(5 * PER, n);
    clks(PER * 3 / 2);
    chk(conversionReadyN, 1'b0);
    chk(falls - f, 1);
    chk(convActive, 1'b0);
    host.shift(adc_readout_pkg::CMD_STOP_CONT_READ, 8, got, rdy);
    clks(8);
    chk(contReadMode, 1'b0);
    host.shift(adc_readout_pkg::CMD_READ_ONCE, 224, got, rdy);
    chk(got[215:0] === expFrame || got[216:1] === expFrame, 1'b1);
    startPin <= 1'b0;
    $display("test single shot done");
    // Start and stop commands act on the seventh falling edge; early stop
    host.shift(adc_readout_pkg::CMD_STOP, 7, got, rdy);
    configRegFour <= 8'h00;
    host.shift(adc_readout_pkg::CMD_START, 7, got, rdy);
    clks(8);
    chk(convActive, 1'b1);
    f = falls;
    host.shift(adc_readout_pkg::CMD_STOP, 7, got, rdy);
    waitFall(5 * PER, n);
    clks(PER * 3 / 2);
    chk(falls - f, 1);
    chk(convActive, 1'b0);
    host.shift(adc_readout_pkg::CMD_CONT_READ, 8, got, rdy);
    clks(8);
    chk(contReadMode, 1'b1);
    $display("test commands done");
    end_of_test();
  end
endmodule // adc_conversion_readout_tb
`default_nettype wire

// *** tb/spi_host_model.sv ***
/*
  Host side of the serial link: select, clock and data in.
  Assumes the device samples these pins on its own clock.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // Link pins
  output var logic spiCsN,
  output var logic spiSclk,
  output var logic spiDin,
  input wire logic spiDout,
  input wire logic spiDoutOe,
  input wire logic conversionReadyN
);
  logic pinDout;

  // A released data line floats; show the inverse so a read outside the enable fails
  assign pinDout = spiDoutOe ? spiDout : ~spiDout;

  initial begin
    spiCsN = 1'b1;
    spiSclk = 1'b0;
    spiDin = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Clock stands low outside frames; data in flips once released
  task automatic shift(input logic [7:0] cmd, input int n, output logic [255:0] got,
      output logic rdy);
    got = '0;
    rdy = 1'b0;
    spiCsN <= 1'b0;
    #100;
    for (int i = 0; i < n; i++) begin
      spiDin <= (i < 8) && cmd[7 - i];
      spiSclk <= 1'b1;
      #80;
      got = {got[254:0], pinDout};
      if (i == 1) rdy = conversionReadyN;
      spiSclk <= 1'b0;
      #80;
    end
    // The device wants a few master clocks before select rises
    #2000;
    spiCsN <= 1'b1;
    spiDin <= ~spiDin;
    // Select must stay high long enough to reset the command counter
    #160;
  endtask
endmodule // spi_host_model
`default_nettype wire
